// ==== tcs_pkg.sv ====
// Summary of operation
// [RULE1] Temperature status code answers one data byte by read byte and write byte.
// [RULE2] Temperature flags clear by clear-faults, output turn-on, or writing one there.
// [RULE3] Temperature flags latch whatever the alert mask says.
// [RULE4] A set fault or warning disable bit blocks its status flag.
// [RULE5] Bit 7 latches on over-temperature fault, stays until cleared.
// [RULE6] Bit 6 latches on over-temperature warning, stays until cleared.
// [RULE7] Unsupported positions are read-only zero: temp 5:0, comm 3, 2, 0.
// [RULE8] Communication status code answers one data byte by read and write byte.
// [RULE9] Communication flags clear by clear-faults, output turn-on, or writing one.
// [RULE10] Communication bit 7 latches on an invalid or unsupported command code.
// [RULE11] Communication bit 6 latches on invalid or unsupported data.
// [RULE12] Communication bit 5 latches on a packet error check mismatch.
// [RULE13] Communication bit 4 latches on any store, restore, boot or programming memory failure.
// [RULE14] Memory flag ignores all clears until fault resolved and memory updated.
// [RULE15] Communication bit 1 latches on any other communication error.
// [RULE16] Summary bit equals OR of supported communication flags.
// [RULE17] Write-one clears of communication flags also clear the summary bit.
// [RULE18] Writing zero, or writing read-only positions, changes nothing.
package tcs_pkg;

  // Command codes
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_TEMP_STATUS  = 8'h7D;
  localparam logic [7:0] CMD_CML_STATUS   = 8'h7E;

  // Temperature status field positions
  localparam int TEMP_OT_FAULT_BIT = 7;
  localparam int TEMP_OT_WARN_BIT  = 6;

  // Communication status field positions
  localparam int CML_BAD_CMD_BIT   = 7;
  localparam int CML_BAD_DATA_BIT  = 6;
  localparam int CML_PEC_BIT       = 5;
  localparam int CML_MEM_BIT       = 4;
  localparam int CML_OTHER_BIT     = 1;

  // Supported positions and reset values
  localparam logic [7:0] TEMP_SUPPORTED = 8'hC0;
  localparam logic [7:0] CML_SUPPORTED  = 8'hF2;
  localparam logic [7:0] STATUS_RESET   = 8'h00;

  // Decoded transaction from the command engine
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] code;
    logic [7:0] data;
  } tcs_req_t;

  // Read answer
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } tcs_rsp_t;

  // Temperature detector events
  typedef struct packed {
    logic overtemp_fault_flag;
    logic overtemp_warning_flag;
  } tcs_temp_evt_t;

  // Fault and warning disable bits
  typedef struct packed {
    logic overtemp_fault_flag;
    logic overtemp_warning_flag;
  } tcs_disable_t;

  // Communication error events
  typedef struct packed {
    logic bad_command_flag;
    logic bad_payload_flag;
    logic pec_fail;
    logic other_comm;
  } tcs_comm_evt_t;

  // Memory failure sources
  typedef struct packed {
    logic store_parity;
    logic boot_mismatch;
    logic restore_parity;
    logic prog_fail;
  } tcs_mem_evt_t;

  // State of one flag byte
  typedef struct packed {
    logic [7:0] flags;
  } tcs_flag_state_t;

  // State of the memory fault tracker
  typedef struct packed {
    logic pending;
  } tcs_mem_state_t;

  // State of the top level
  typedef struct packed {
    tcs_rsp_t rsp;
  } tcs_top_state_t;

endpackage

// ==== tcs_flag_byte.sv ====
`timescale 1ns/100ps
module tcs_flag_byte #(
  parameter logic [7:0] SUPPORTED = 8'h00
) (
  input  logic       clk_sys_i,
  input  logic       sys_rst_i,
  input  logic [7:0] set_i,
  input  logic [7:0] clr_i,
  input  logic [7:0] hold_i,
  output logic [7:0] flags_o
);

  tcs_pkg::tcs_flag_state_t state;
  tcs_pkg::tcs_flag_state_t next_state;
  logic [7:0]               next_flags;

  // Per-bit latch, set beats clear, hold blocks clear, unsupported stays zero
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_bit
      assign next_flags[i] = SUPPORTED[i] &
                             (set_i[i] | (state.flags[i] & ~(clr_i[i] & ~hold_i[i])));
    end
  endgenerate

  // Next state
  always_comb begin
    next_state       = state;
    next_state.flags = next_flags;
  end

  // State register
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state.flags <= tcs_pkg::STATUS_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign flags_o = state.flags;

endmodule

// ==== tcs_mem_fault_track.sv ====
`timescale 1ns/100ps
module tcs_mem_fault_track (
  input  logic                  clk_sys_i,
  input  logic                  sys_rst_i,
  input  tcs_pkg::tcs_mem_evt_t mem_evt_i,
  input  logic                  mem_updated_i,
  output logic                  fault_o,
  output logic                  pending_o
);

  tcs_pkg::tcs_mem_state_t state;
  tcs_pkg::tcs_mem_state_t next_state;

  // Any memory failure source
  assign fault_o = |mem_evt_i;

  // Pending until a successful update, new failure wins
  always_comb begin
    next_state         = state;
    next_state.pending = fault_o | (state.pending & ~mem_updated_i);
  end

  // State register
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state.pending <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  assign pending_o = state.pending;

endmodule

// ==== tcs_status_regs.sv ====
`timescale 1ns/100ps
module tcs_status_regs (
  input  logic                   clk_sys_i,
  input  logic                   sys_rst_i,
  input  tcs_pkg::tcs_req_t      req_i,
  input  tcs_pkg::tcs_temp_evt_t temp_evt_i,
  input  tcs_pkg::tcs_disable_t  fault_disable_i,
  input  tcs_pkg::tcs_comm_evt_t comm_evt_i,
  input  tcs_pkg::tcs_mem_evt_t  mem_evt_i,
  input  logic                   mem_updated_i,
  input  logic                   output_on_i,
  output tcs_pkg::tcs_rsp_t      rsp_o,
  output logic [7:0]             temp_status_o,
  output logic [7:0]             cml_status_o,
  output logic                   cml_summary_o
);

  tcs_pkg::tcs_top_state_t state;
  tcs_pkg::tcs_top_state_t next_state;

  logic       hit_temp;
  logic       hit_cml;
  logic       wr_temp;
  logic       wr_cml;
  logic       rd_req;
  logic       clear_all;
  logic       mem_fault;
  logic       mem_pending;
  logic [7:0] temp_set;
  logic [7:0] temp_clr;
  logic [7:0] cml_set;
  logic [7:0] cml_clr;
  logic [7:0] cml_hold;

  // Command decode
  assign hit_temp  = req_i.valid & (req_i.code == tcs_pkg::CMD_TEMP_STATUS);
  assign hit_cml   = req_i.valid & (req_i.code == tcs_pkg::CMD_CML_STATUS);
  assign wr_temp   = hit_temp & req_i.write;
  assign wr_cml    = hit_cml & req_i.write;
  assign rd_req    = (hit_temp | hit_cml) & ~req_i.write;
  assign clear_all = (req_i.valid & req_i.write & (req_i.code == tcs_pkg::CMD_CLEAR_FAULTS))
                   | output_on_i; // RULE2 RULE9

  // Temperature sets, gated by disables only, never by the alert mask
  always_comb begin // RULE3
    temp_set = tcs_pkg::STATUS_RESET;
    temp_set[tcs_pkg::TEMP_OT_FAULT_BIT] = temp_evt_i.overtemp_fault_flag &
                                           ~fault_disable_i.overtemp_fault_flag; // RULE4 RULE5
    temp_set[tcs_pkg::TEMP_OT_WARN_BIT]  = temp_evt_i.overtemp_warning_flag &
                                           ~fault_disable_i.overtemp_warning_flag; // RULE4 RULE6
  end

  // Temperature clears: global clear or write-one
  assign temp_clr = {8{clear_all}} |
                    (wr_temp ? req_i.data : tcs_pkg::STATUS_RESET); // RULE2 RULE18

  // Communication sets
  always_comb begin
    cml_set = tcs_pkg::STATUS_RESET;
    cml_set[tcs_pkg::CML_BAD_CMD_BIT]  = comm_evt_i.bad_command_flag; // RULE10
    cml_set[tcs_pkg::CML_BAD_DATA_BIT] = comm_evt_i.bad_payload_flag; // RULE11
    cml_set[tcs_pkg::CML_PEC_BIT]      = comm_evt_i.pec_fail; // RULE12
    cml_set[tcs_pkg::CML_MEM_BIT]      = mem_fault; // RULE13
    cml_set[tcs_pkg::CML_OTHER_BIT]    = comm_evt_i.other_comm; // RULE15
  end

  // Communication clears, memory bit held while its fault is pending
  assign cml_clr = {8{clear_all}} | (wr_cml ? req_i.data : tcs_pkg::STATUS_RESET); // RULE9 RULE18
  always_comb begin
    cml_hold = tcs_pkg::STATUS_RESET;
    cml_hold[tcs_pkg::CML_MEM_BIT] = mem_pending; // RULE14
  end

  // Temperature flag byte
  tcs_flag_byte #(
    .SUPPORTED (tcs_pkg::TEMP_SUPPORTED)
  ) u_temp_flags (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .set_i     (temp_set),
    .clr_i     (temp_clr),
    .hold_i    (tcs_pkg::STATUS_RESET),
    .flags_o   (temp_status_o)
  ); // RULE7

  // Communication flag byte
  tcs_flag_byte #(
    .SUPPORTED (tcs_pkg::CML_SUPPORTED)
  ) u_cml_flags (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .set_i     (cml_set),
    .clr_i     (cml_clr),
    .hold_i    (cml_hold),
    .flags_o   (cml_status_o)
  ); // RULE7

  // Memory fault tracker
  tcs_mem_fault_track u_mem_track (
    .clk_sys_i     (clk_sys_i),
    .sys_rst_i     (sys_rst_i),
    .mem_evt_i     (mem_evt_i),
    .mem_updated_i (mem_updated_i),
    .fault_o       (mem_fault),
    .pending_o     (mem_pending)
  );

  // Summary follows the flags, so write-one clears drop it too
  assign cml_summary_o = |cml_status_o; // RULE16 RULE17

  // Read answer: one byte, one cycle after the request
  always_comb begin
    next_state           = state;
    next_state.rsp.valid = rd_req; // RULE1 RULE8
    if (rd_req) begin
      next_state.rsp.data = hit_temp ? temp_status_o : cml_status_o;
    end
  end

  // State register
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state.rsp.valid <= 1'b0;
      state.rsp.data  <= tcs_pkg::STATUS_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign rsp_o = state.rsp;

  // Fault event latches next cycle
  ot_fault_set_a: assert property ( // RULE5
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    temp_evt_i.overtemp_fault_flag && !fault_disable_i.overtemp_fault_flag
    |=> temp_status_o[tcs_pkg::TEMP_OT_FAULT_BIT])
    else $error("overtemp fault not latched");

  // Warning event latches next cycle
  ot_warn_set_a: assert property ( // RULE6
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    temp_evt_i.overtemp_warning_flag && !fault_disable_i.overtemp_warning_flag
    |=> temp_status_o[tcs_pkg::TEMP_OT_WARN_BIT])
    else $error("overtemp warning not latched");

  // Fault flag stays without a clear
  ot_fault_hold_a: assert property ( // RULE5
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    temp_status_o[tcs_pkg::TEMP_OT_FAULT_BIT] && !clear_all && !wr_temp
    |=> temp_status_o[tcs_pkg::TEMP_OT_FAULT_BIT])
    else $error("overtemp fault dropped");

  // Flag rises only from an enabled event
  disable_block_a: assert property ( // RULE4
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    $rose(temp_status_o[tcs_pkg::TEMP_OT_WARN_BIT])
    |-> $past(temp_evt_i.overtemp_warning_flag) && !$past(fault_disable_i.overtemp_warning_flag))
    else $error("warning set while disabled");

  // Unsupported positions read zero
  reserved_zero_a: assert property ( // RULE7
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    ((temp_status_o & ~tcs_pkg::TEMP_SUPPORTED) == 8'h00) &&
    ((cml_status_o & ~tcs_pkg::CML_SUPPORTED) == 8'h00))
    else $error("unsupported bit set");

  // Clear-faults empties temperature byte
  clear_faults_a: assert property ( // RULE2
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    clear_all && (temp_set == 8'h00) |=> temp_status_o == 8'h00)
    else $error("clear faults left temperature flags");

  // Write-one clears communication bits except a held memory bit
  cml_w1c_a: assert property ( // RULE9
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    wr_cml && (cml_set == 8'h00) && !mem_pending
    |=> (cml_status_o & $past(req_i.data)) == 8'h00)
    else $error("write one did not clear");

  // Writing zero leaves both bytes alone
  write_zero_a: assert property ( // RULE18
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (wr_temp || wr_cml) && (req_i.data == 8'h00) && !output_on_i &&
    (temp_set == 8'h00) && (cml_set == 8'h00)
    |=> $stable(temp_status_o) && $stable(cml_status_o))
    else $error("zero write changed flags");

  // Bad command latches
  bad_cmd_set_a: assert property ( // RULE10
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    comm_evt_i.bad_command_flag |=> cml_status_o[tcs_pkg::CML_BAD_CMD_BIT])
    else $error("bad command not latched");

  // Bad data latches
  bad_data_set_a: assert property ( // RULE11
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    comm_evt_i.bad_payload_flag |=> cml_status_o[tcs_pkg::CML_BAD_DATA_BIT])
    else $error("bad payload not latched");

  // Check byte mismatch latches
  pec_set_a: assert property ( // RULE12
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    comm_evt_i.pec_fail |=> cml_status_o[tcs_pkg::CML_PEC_BIT])
    else $error("check byte failure not latched");

  // Any memory source latches
  mem_set_a: assert property ( // RULE13
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (mem_evt_i != 4'h0) |=> cml_status_o[tcs_pkg::CML_MEM_BIT] && mem_pending)
    else $error("memory failure not latched");

  // Memory flag survives every clear while pending
  mem_hold_a: assert property ( // RULE14
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    cml_status_o[tcs_pkg::CML_MEM_BIT] && mem_pending && !mem_updated_i
    |=> cml_status_o[tcs_pkg::CML_MEM_BIT])
    else $error("memory flag cleared while pending");

  // Other error latches
  other_set_a: assert property ( // RULE15
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    comm_evt_i.other_comm |=> cml_status_o[tcs_pkg::CML_OTHER_BIT])
    else $error("other error not latched");

  // Summary tracks flags
  summary_or_a: assert property ( // RULE16
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    cml_summary_o == (|(cml_status_o & tcs_pkg::CML_SUPPORTED)))
    else $error("summary mismatch");

  // Full write-one clear drops the summary
  summary_clear_a: assert property ( // RULE17
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    wr_cml && (req_i.data == 8'hFF) && (cml_set == 8'h00) && !mem_pending
    |=> !cml_summary_o)
    else $error("summary not cleared");

  // Temperature read answers next cycle with the byte
  temp_read_a: assert property ( // RULE1
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    hit_temp && !req_i.write |=> rsp_o.valid && (rsp_o.data == $past(temp_status_o)))
    else $error("temperature read answer wrong");

  // Communication read answers next cycle with the byte
  cml_read_a: assert property ( // RULE8
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    hit_cml && !req_i.write |=> rsp_o.valid && (rsp_o.data == $past(cml_status_o)))
    else $error("communication read answer wrong");

  // No answer without a read
  no_spurious_rsp_a: assert property ( // RULE1
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    !rd_req |=> !rsp_o.valid)
    else $error("answer without read");

  // Warning flag stays without a clear
  ot_warn_hold_a: assert property ( // RULE6
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    temp_status_o[tcs_pkg::TEMP_OT_WARN_BIT] && !clear_all && !wr_temp
    |=> temp_status_o[tcs_pkg::TEMP_OT_WARN_BIT])
    else $error("overtemp warning dropped");

  // Fault flag rises only from an enabled event
  fault_gate_a: assert property ( // RULE4
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    $rose(temp_status_o[tcs_pkg::TEMP_OT_FAULT_BIT])
    |-> $past(temp_evt_i.overtemp_fault_flag) && !$past(fault_disable_i.overtemp_fault_flag))
    else $error("fault set while disabled");

  // Write-one clears temperature bits
  temp_w1c_a: assert property ( // RULE2
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    wr_temp && (temp_set == 8'h00)
    |=> (temp_status_o & $past(req_i.data)) == 8'h00)
    else $error("temperature write one did not clear");

  // Global clear empties communication byte once the hold is gone
  cml_clear_all_a: assert property ( // RULE9
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    clear_all && (cml_set == 8'h00) && !mem_pending |=> cml_status_o == 8'h00)
    else $error("clear faults left communication flags");

  // Update with no new failure releases the hold
  mem_release_a: assert property ( // RULE14
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    mem_pending && mem_updated_i && (mem_evt_i == 4'h0) |=> !mem_pending)
    else $error("memory hold not released");

  // Any communication event raises the summary
  summary_set_a: assert property ( // RULE16
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (cml_set != 8'h00) |=> cml_summary_o)
    else $error("summary not raised");

  // Writes to read-only temperature bits change nothing
  ro_write_a: assert property ( // RULE18
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    wr_temp && ((req_i.data & tcs_pkg::TEMP_SUPPORTED) == 8'h00) && !output_on_i &&
    (temp_set == 8'h00)
    |=> $stable(temp_status_o))
    else $error("read-only write changed flags");

  // Answer byte holds between reads
  rsp_hold_a: assert property ( // RULE1
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    !rd_req |=> $stable(rsp_o.data))
    else $error("answer byte changed without read");

  // Bad command flag falls only through a clear
  bad_cmd_clear_a: assert property ( // RULE10
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    $fell(cml_status_o[tcs_pkg::CML_BAD_CMD_BIT]) && !$past(sys_rst_i)
    |-> $past(clear_all) || ($past(wr_cml) && $past(req_i.data[tcs_pkg::CML_BAD_CMD_BIT])))
    else $error("bad command flag dropped");

endmodule

// ==== tcs_host_model.sv ====
`timescale 1ns/100ps
module tcs_host_model (
  input  logic              clk_sys_i,
  output tcs_pkg::tcs_req_t req_o
);
  // Idle at start so nothing is taken during reset
  initial req_o = '0;

  // One-cycle request; released fields flip so stale values never look valid
  always @(posedge clk_sys_i) begin
    if (req_o.valid) begin
      req_o <= {1'b0, ~req_o[16:0]};
    end
  end

  // Issue one transaction, called just after a falling edge
  task automatic send(input logic w, input logic [7:0] code, input logic [7:0] data);
    req_o = {1'b1, w, code, data};
  endtask
endmodule

// ==== tcs_status_regs_tb.sv ====
`timescale 1ns/100ps
module tcs_status_regs_tb;
  logic                   clk_sys_i = 1'b0;
  logic                   sys_rst_i = 1'b1;
  tcs_pkg::tcs_req_t      req;
  tcs_pkg::tcs_rsp_t      rsp;
  logic [7:0]             temp_st;
  logic [7:0]             cml_st;
  logic                   summary;
  tcs_pkg::tcs_temp_evt_t d_temp = '0;
  tcs_pkg::tcs_disable_t  d_dis = '0;
  tcs_pkg::tcs_comm_evt_t d_comm = '0;
  tcs_pkg::tcs_mem_evt_t  d_mem = '0;
  logic                   d_upd = 1'b0;
  logic                   d_on = 1'b0;
  // Stimulus staged for the next step
  tcs_pkg::tcs_temp_evt_t s_temp = '0;
  tcs_pkg::tcs_disable_t  s_dis = '0;
  tcs_pkg::tcs_comm_evt_t s_comm = '0;
  tcs_pkg::tcs_mem_evt_t  s_mem = '0;
  logic                   s_upd = 1'b0;
  logic                   s_on = 1'b0;
  logic                   rq = 1'b0;
  logic                   rq_w = 1'b0;
  logic [7:0]             rq_code = 8'h00;
  logic [7:0]             rq_data = 8'h00;
  // Expected state
  logic [7:0]             exp_temp = 8'h00;
  logic [7:0]             exp_cml = 8'h00;
  logic [7:0]             exp_data = 8'h00;
  logic                   exp_valid = 1'b0;
  logic                   exp_pend = 1'b0;
  int                     n_errors = 0;
  int                     check_count = 0;
  int                     seed = 8;
  logic [7:0]             codes [4] = '{8'h03, 8'h7d, 8'h7e, 8'h00};

  // Clock
  always #12.5 clk_sys_i = ~clk_sys_i;

  tcs_host_model host (
    .clk_sys_i (clk_sys_i),
    .req_o     (req)
  );

  tcs_status_regs DUT (
    .clk_sys_i       (clk_sys_i),
    .sys_rst_i       (sys_rst_i),
    .req_i           (req),
    .temp_evt_i      (d_temp),
    .fault_disable_i (d_dis),
    .comm_evt_i      (d_comm),
    .mem_evt_i       (d_mem),
    .mem_updated_i   (d_upd),
    .output_on_i     (d_on),
    .rsp_o           (rsp),
    .temp_status_o   (temp_st),
    .cml_status_o    (cml_st),
    .cml_summary_o   (summary)
  );

  // Latched flag byte: sets win, clears blocked where held
  function automatic logic [7:0] nxt(input logic [7:0] cur, input logic [7:0] set,
                                     input logic [7:0] clr, input logic [7:0] hold,
                                     input logic [7:0] sup);
    return ((cur & ~(clr & ~hold)) | set) & sup;
  endfunction

  // Byte comparison
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Drive one cycle, predict it, then compare after the edge
  task automatic step;
    logic       clr_all;
    logic       mem_any;
    logic [7:0] t_clr;
    logic [7:0] c_clr;
    logic [7:0] t_set;
    logic [7:0] c_set;
    d_temp = s_temp;
    d_dis = s_dis;
    d_comm = s_comm;
    d_mem = s_mem;
    d_upd = s_upd;
    d_on = s_on;
    if (rq) host.send(rq_w, rq_code, rq_data);
    clr_all = d_on | (rq & rq_w & (rq_code == tcs_pkg::CMD_CLEAR_FAULTS));
    mem_any = |d_mem;
    t_set = {d_temp.overtemp_fault_flag & ~d_dis.overtemp_fault_flag,
             d_temp.overtemp_warning_flag & ~d_dis.overtemp_warning_flag, 6'h00};
    c_set = {d_comm.bad_command_flag, d_comm.bad_payload_flag, d_comm.pec_fail, mem_any,
             2'h0, d_comm.other_comm, 1'b0};
    t_clr = clr_all ? 8'hff :
            ((rq & rq_w & (rq_code == tcs_pkg::CMD_TEMP_STATUS)) ? rq_data : 8'h00);
    c_clr = clr_all ? 8'hff :
            ((rq & rq_w & (rq_code == tcs_pkg::CMD_CML_STATUS)) ? rq_data : 8'h00);
    exp_valid = rq & ~rq_w &
                ((rq_code == tcs_pkg::CMD_TEMP_STATUS) | (rq_code == tcs_pkg::CMD_CML_STATUS));
    if (exp_valid) exp_data = (rq_code == tcs_pkg::CMD_TEMP_STATUS) ? exp_temp : exp_cml;
    exp_temp = nxt(exp_temp, t_set, t_clr, 8'h00, tcs_pkg::TEMP_SUPPORTED);
    exp_cml = nxt(exp_cml, c_set, c_clr, exp_pend ? 8'h10 : 8'h00, tcs_pkg::CML_SUPPORTED);
    exp_pend = mem_any | (exp_pend & ~d_upd);
    @(negedge clk_sys_i);
    chk8(temp_st, exp_temp, "temp flags");
    chk8(cml_st, exp_cml, "comm flags");
    chk8({7'h00, summary}, {7'h00, |exp_cml}, "summary");
    chk8({7'h00, rsp.valid}, {7'h00, exp_valid}, "answer strobe");
    chk8(rsp.data, exp_data, "answer byte");
    s_temp = '0;
    s_dis = '0;
    s_comm = '0;
    s_mem = '0;
    s_upd = 1'b0;
    s_on = 1'b0;
    rq = 1'b0;
  endtask

  // Directed step with one transaction
  task automatic go(input logic r, input logic w, input logic [7:0] c, input logic [7:0] d);
    rq = r;
    rq_w = w;
    rq_code = c;
    rq_data = d;
    step();
  endtask

  // Sparse random events and transactions
  task automatic rand_step;
    s_temp = (($random(seed) & 3) == 0) ? 2'($random(seed)) : 2'h0;
    s_dis = (($random(seed) & 3) == 0) ? 2'($random(seed)) : 2'h0;
    s_comm = (($random(seed) & 7) == 0) ? 4'($random(seed)) : 4'h0;
    s_mem = (($random(seed) & 31) == 0) ? 4'($random(seed)) : 4'h0;
    s_upd = (($random(seed) & 7) == 0);
    s_on = (($random(seed) & 31) == 0);
    codes[3] = 8'($random(seed));
    go($random(seed) & 1, $random(seed) & 1, codes[$random(seed) & 3], 8'($random(seed)));
  endtask

  // Verdict and end of run
  task automatic complete_run;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    #(25 * 10000);
    n_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    complete_run();
  end

  // Main sequence
  initial begin
    repeat (8) @(negedge clk_sys_i);
    sys_rst_i = 1'b0;
    @(negedge clk_sys_i);
    // Disabled fault blocked, warning latches; read-only and zero writes ignored
    s_temp = 2'h3;
    s_dis = 2'h2;
    go(1'b1, 1'b0, tcs_pkg::CMD_TEMP_STATUS, 8'h00);
    go(1'b1, 1'b1, tcs_pkg::CMD_TEMP_STATUS, 8'h3f);
    s_comm = 4'hf;
    go(1'b1, 1'b1, tcs_pkg::CMD_CML_STATUS, 8'h00);
    go(1'b1, 1'b1, tcs_pkg::CMD_CML_STATUS, 8'h0d);
    go(1'b1, 1'b0, tcs_pkg::CMD_CML_STATUS, 8'h00);
    go(1'b1, 1'b1, tcs_pkg::CMD_CML_STATUS, 8'h82);
    go(1'b1, 1'b1, tcs_pkg::CMD_CML_STATUS, 8'h60);
    go(1'b1, 1'b1, tcs_pkg::CMD_TEMP_STATUS, 8'h40);
    // Each memory source; clears held until the update
    for (int i = 0; i < 4; i++) begin
      s_mem = 4'(1 << i);
      go(1'b1, 1'b1, tcs_pkg::CMD_CML_STATUS, 8'hff);
      s_on = 1'b1;
      go(1'b1, 1'b1, tcs_pkg::CMD_CLEAR_FAULTS, 8'h00);
      s_upd = 1'b1;
      go(1'b1, 1'b1, tcs_pkg::CMD_CML_STATUS, 8'h10);
      go(1'b1, 1'b1, tcs_pkg::CMD_CML_STATUS, 8'h10);
    end
    // Mid-run reset drops flags, hold and answer; first request a cycle later
    s_temp = 2'h3;
    s_comm = 4'hf;
    s_mem = 4'h8;
    go(1'b1, 1'b0, tcs_pkg::CMD_CML_STATUS, 8'h00);
    sys_rst_i = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    sys_rst_i = 1'b0;
    exp_temp = 8'h00;
    exp_cml = 8'h00;
    exp_data = 8'h00;
    exp_pend = 1'b0;
    go(1'b0, 1'b0, 8'h00, 8'h00);
    go(1'b1, 1'b0, tcs_pkg::CMD_TEMP_STATUS, 8'h00);
    repeat (3000) rand_step();
    complete_run();
  end
endmodule
